/* File: rtl/ppm_port_ctrl.sv */
// Pin mode control for port-three pins 2:0 and port-four pins 7:4 behind an APB slave.
//
// Summary of operation
// - Reset loads port-three low mode register with 9B, making pins open-drain.
// - Pin two field 7:6: 00 input, 01 pull-up, 10 open-drain, 11 push-pull.
// - Pins one and zero fields: 000 input, 001 pull-up, 011 open-drain, 1xx push-pull.
// - Code 010 selects analog input fourteen on pin one, thirteen on pin zero.
// - Reset loads port-four high mode register with AA, making pins open-drain.
// - Port-four high register: four 2-bit fields, pin seven at 7:6 down to pin four.
// - Data bit reads pin level for inputs, sets driven level for outputs.
`timescale 1ns/1ps
module ppm_port_ctrl
  import ppm_pkg::*;
(
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Port-three pins 2:0
  input  wire logic [2:0]            p3_pad_in,
  output logic [2:0]                 p3_pad_out,
  output logic [2:0]                 p3_pad_oe_n,
  output logic [2:0]                 p3_pull_up_en,
  // Port-four pins 7:4
  input  wire logic [3:0]            p4_pad_in,
  output logic [3:0]                 p4_pad_out,
  output logic [3:0]                 p4_pad_oe_n,
  output logic [3:0]                 p4_pull_up_en,
  // Analog input selects toward the converter
  output logic                       adc_input_thirteen,
  output logic                       adc_input_fourteen
);

  localparam int NUM_PINS = 7;

  logic [7:0]   port3_low_pin_mode;
  logic [7:0]   port4_high_pin_mode;
  logic [7:0]   port3_pin_data;
  logic [7:0]   port4_pin_data;

  ppm_mode_type pin_mode [NUM_PINS];
  logic [NUM_PINS-1:0] pin_out_level;
  logic [NUM_PINS-1:0] pad_in_all;
  logic [NUM_PINS-1:0] pad_out_all;
  logic [NUM_PINS-1:0] pad_oe_n_all;
  logic [NUM_PINS-1:0] pull_up_all;
  logic [NUM_PINS-1:0] alt_sel_all;
  logic [NUM_PINS-1:0] pin_level_all;

  logic                wr_en;
  logic                addr_hit;
  logic                hit_p3_mode;
  logic                hit_p4_mode;
  logic                hit_p3_data;
  logic                hit_p4_data;
  logic [7:0]          next_rdata;
  logic [7:0]          p3_read;
  logic [7:0]          p4_read;

  // ---------------- APB decode ----------------
  assign hit_p3_mode = (paddr == ppm_byte_addr(IDX_P3_MODE));
  assign hit_p4_mode = (paddr == ppm_byte_addr(IDX_P4_MODE));
  assign hit_p3_data = (paddr == ppm_byte_addr(IDX_P3_DATA));
  assign hit_p4_data = (paddr == ppm_byte_addr(IDX_P4_DATA));
  assign addr_hit    = hit_p3_mode | hit_p4_mode | hit_p3_data | hit_p4_data;

  // Zero wait states: the read word is prepared during the setup cycle.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;
  // A write with the low byte lane off stores nothing; only bits 7:0 exist.
  assign wr_en   = psel & penable & pwrite & addr_hit & pstrb[0];

  // ---------------- Mode registers ----------------
  // port-three reset value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port3_low_pin_mode <= RST_P3_MODE;
    end else if (wr_en && hit_p3_mode) begin
      port3_low_pin_mode <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port4_high_pin_mode <= RST_P4_MODE;
    end else if (wr_en && hit_p4_mode) begin
      port4_high_pin_mode <= pwdata[7:0];
    end
  end

  // ---------------- Data latches ----------------
  // output latch written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port3_pin_data <= RST_P3_DATA;
    end else if (wr_en && hit_p3_data) begin
      port3_pin_data <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port4_pin_data <= RST_P4_DATA;
    end else if (wr_en && hit_p4_data) begin
      port4_pin_data <= pwdata[7:0];
    end
  end

  // ---------------- Mode decode ----------------
  // pin two field
  always_comb begin
    pin_mode[0] = ppm_decode3(port3_low_pin_mode[P3_PIN0_LSB +: 3]);
    pin_mode[1] = ppm_decode3(port3_low_pin_mode[P3_PIN1_LSB +: 3]);
    pin_mode[2] = ppm_decode2(port3_low_pin_mode[P3_PIN2_LSB +: 2]);
    for (int i = 0; i < 4; i++) begin
      pin_mode[3 + i] = ppm_decode2(port4_high_pin_mode[2 * i +: 2]);
    end
  end

  assign pin_out_level = {port4_pin_data[7:P4_PIN_BASE], port3_pin_data[2:0]};
  assign pad_in_all    = {p4_pad_in, p3_pad_in};

  // ---------------- Pin cells ----------------
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    ppm_pin_cell u_cell (
      .pclk       (pclk),
      .presetn    (presetn),
      .mode       (pin_mode[g]),
      .out_level  (pin_out_level[g]),
      .pad_in     (pad_in_all[g]),
      .pad_out    (pad_out_all[g]),
      .pad_oe_n   (pad_oe_n_all[g]),
      .pull_up_en (pull_up_all[g]),
      .alt_sel    (alt_sel_all[g]),
      .pin_level  (pin_level_all[g])
    );
  end

  assign p3_pad_out    = pad_out_all[2:0];
  assign p3_pad_oe_n   = pad_oe_n_all[2:0];
  assign p3_pull_up_en = pull_up_all[2:0];
  assign p4_pad_out    = pad_out_all[6:3];
  assign p4_pad_oe_n   = pad_oe_n_all[6:3];
  assign p4_pull_up_en = pull_up_all[6:3];

  // analog selects
  // The converter must still be enabled by software before the channel is usable.
  assign adc_input_thirteen = alt_sel_all[0];
  assign adc_input_fourteen = alt_sel_all[1];

  // ---------------- Read-back ----------------
  // input read-back
  // Bits without a pin here read back the stored latch.
  always_comb begin
    p3_read = port3_pin_data;
    p4_read = port4_pin_data;
    for (int i = 0; i < 3; i++) begin
      if (ppm_is_input(pin_mode[i])) begin
        p3_read[i] = pin_level_all[i];
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (ppm_is_input(pin_mode[3 + i])) begin
        p4_read[P4_PIN_BASE + i] = pin_level_all[3 + i];
      end
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (hit_p3_mode) begin
      next_rdata = port3_low_pin_mode;
    end else if (hit_p4_mode) begin
      next_rdata = port4_high_pin_mode;
    end else if (hit_p3_data) begin
      next_rdata = p3_read;
    end else if (hit_p4_data) begin
      next_rdata = p4_read;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, next_rdata};
    end
  end

  // ---------------- Checks ----------------
  logic rst_seen;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_seen <= 1'b0;
    end else begin
      rst_seen <= 1'b1;
    end
  end

  property p_p3_reset;
    @(posedge pclk) disable iff (!presetn)
      !rst_seen |-> port3_low_pin_mode == RST_P3_MODE;
  endproperty
  a_p3_reset: assert property (p_p3_reset)
    else $error("Port-three mode register wrong after reset.");

  property p_p4_reset;
    @(posedge pclk) disable iff (!presetn)
      !rst_seen |-> port4_high_pin_mode == RST_P4_MODE;
  endproperty
  a_p4_reset: assert property (p_p4_reset)
    else $error("Port-four mode register wrong after reset.");

  property p_pin2_push_pull;
    @(posedge pclk) disable iff (!presetn)
      (port3_low_pin_mode[7:6] == 2'h3)[*2] |-> !p3_pad_oe_n[2] && !p3_pull_up_en[2];
  endproperty
  a_pin2_push_pull: assert property (p_pin2_push_pull)
    else $error("Pin two not push-pull under code 11.");

  property p_pin1_push_pull;
    @(posedge pclk) disable iff (!presetn)
      port3_low_pin_mode[5] ##1 port3_low_pin_mode[5]
        |-> !p3_pad_oe_n[1] && (p3_pad_out[1] == $past(port3_pin_data[1]));
  endproperty
  a_pin1_push_pull: assert property (p_pin1_push_pull)
    else $error("Pin one not push-pull under code 1xx.");

  property p_pin0_analog;
    @(posedge pclk) disable iff (!presetn)
      (port3_low_pin_mode[2:0] == 3'h2)[*2] |-> adc_input_thirteen && p3_pad_oe_n[0];
  endproperty
  a_pin0_analog: assert property (p_pin0_analog)
    else $error("Pin zero not handed to analog input thirteen.");

  property p_pin7_open_drain;
    @(posedge pclk) disable iff (!presetn)
      (port4_high_pin_mode[7:6] == 2'h2 && !port4_pin_data[7])[*2]
        |-> !p4_pad_oe_n[3] && !p4_pad_out[3];
  endproperty
  a_pin7_open_drain: assert property (p_pin7_open_drain)
    else $error("Pin seven open-drain does not pull low.");

  property p_read_pin_level;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_p3_data && ppm_is_input(pin_mode[0]))
        |=> prdata[0] == $past(pin_level_all[0]);
  endproperty
  a_read_pin_level: assert property (p_read_pin_level)
    else $error("Input pin level not returned on read.");

  property p_pin1_analog;
    @(posedge pclk) disable iff (!presetn)
      (port3_low_pin_mode[5:3] == 3'h2)[*2] |-> adc_input_fourteen && p3_pad_oe_n[1];
  endproperty
  a_pin1_analog: assert property (p_pin1_analog)
    else $error("Pin one not handed to analog input fourteen.");

  property p_pin0_release;
    @(posedge pclk) disable iff (!presetn)
      (port3_low_pin_mode[2:0] == 3'h3 && port3_pin_data[0])[*2]
        |-> p3_pad_oe_n[0] && !adc_input_thirteen;
  endproperty
  a_pin0_release: assert property (p_pin0_release)
    else $error("Pin zero open-drain does not release on a one.");

  property p_pin2_input;
    @(posedge pclk) disable iff (!presetn)
      (port3_low_pin_mode[7:6] == 2'h0)[*2] |-> p3_pad_oe_n[2] && !p3_pull_up_en[2];
  endproperty
  a_pin2_input: assert property (p_pin2_input)
    else $error("Pin two not a plain input under code 00.");

  property p_pin4_pull_up;
    @(posedge pclk) disable iff (!presetn)
      (port4_high_pin_mode[1:0] == 2'h1)[*2] |-> p4_pull_up_en[0] && p4_pad_oe_n[0];
  endproperty
  a_pin4_pull_up: assert property (p_pin4_pull_up)
    else $error("Pin four not a pull-up input under code 01.");

  property p_data_write;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && hit_p3_data && pstrb[0])
        |=> port3_pin_data == $past(pwdata[7:0]);
  endproperty
  a_data_write: assert property (p_data_write)
    else $error("Port-three data write did not land.");

  property p_read_latch;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_p4_data && !ppm_is_input(pin_mode[6]))
        |=> prdata[7] == $past(port4_pin_data[7]);
  endproperty
  a_read_latch: assert property (p_read_latch)
    else $error("Output pin read does not return the latch.");

endmodule : ppm_port_ctrl

/* File: include/ppm_pkg.sv */
// Package for the port pin mode control block: register map, reset values and mode decoding.
package ppm_pkg;

  // APB address width; registers sit at four times their index.
  localparam int ADDR_WIDTH = 12;

  // Register indices.
  localparam logic [7:0] IDX_P3_DATA = 8'hc3;
  localparam logic [7:0] IDX_P4_DATA = 8'hc4;
  localparam logic [7:0] IDX_P3_MODE = 8'hd9;
  localparam logic [7:0] IDX_P4_MODE = 8'hdb;

  // Values after reset.
  localparam logic [7:0] RST_P3_MODE = 8'h9b;
  localparam logic [7:0] RST_P4_MODE = 8'haa;
  localparam logic [7:0] RST_P3_DATA = 8'h07;
  localparam logic [7:0] RST_P4_DATA = 8'hff;

  // Field positions in the port-three low mode register.
  localparam int P3_PIN2_LSB = 6;
  localparam int P3_PIN1_LSB = 3;
  localparam int P3_PIN0_LSB = 0;

  // Port-four high pins occupy data bits 7:4.
  localparam int P4_PIN_BASE = 4;

  // Field codes.
  localparam logic [1:0] M2_INPUT      = 2'h0;
  localparam logic [1:0] M2_PULL_UP    = 2'h1;
  localparam logic [1:0] M2_OPEN_DRAIN = 2'h2;
  localparam logic [2:0] M3_INPUT      = 3'h0;
  localparam logic [2:0] M3_PULL_UP    = 3'h1;
  localparam logic [2:0] M3_ALT        = 3'h2;
  localparam logic [2:0] M3_OPEN_DRAIN = 3'h3;

  typedef enum logic [2:0] {
    PPM_INPUT,
    PPM_PULL_UP,
    PPM_OPEN_DRAIN,
    PPM_PUSH_PULL,
    PPM_ALT
  } ppm_mode_type;

  function automatic ppm_mode_type ppm_decode2(input logic [1:0] code);
    unique case (code)
      M2_INPUT:      ppm_decode2 = PPM_INPUT;
      M2_PULL_UP:    ppm_decode2 = PPM_PULL_UP;
      M2_OPEN_DRAIN: ppm_decode2 = PPM_OPEN_DRAIN;
      default:       ppm_decode2 = PPM_PUSH_PULL;
    endcase
  endfunction : ppm_decode2

  // Any code with the top bit set is push-pull.
  function automatic ppm_mode_type ppm_decode3(input logic [2:0] code);
    if (code[2]) begin
      ppm_decode3 = PPM_PUSH_PULL;
    end else begin
      unique case (code)
        M3_INPUT:   ppm_decode3 = PPM_INPUT;
        M3_PULL_UP: ppm_decode3 = PPM_PULL_UP;
        M3_ALT:     ppm_decode3 = PPM_ALT;
        default:    ppm_decode3 = PPM_OPEN_DRAIN;
      endcase
    end
  endfunction : ppm_decode3

  function automatic logic [ADDR_WIDTH-1:0] ppm_byte_addr(input logic [7:0] idx);
    ppm_byte_addr = {2'b00, idx, 2'b00};
  endfunction : ppm_byte_addr

  function automatic logic ppm_is_input(input ppm_mode_type mode);
    ppm_is_input = (mode == PPM_INPUT) || (mode == PPM_PULL_UP) || (mode == PPM_ALT);
  endfunction : ppm_is_input

endpackage : ppm_pkg

/* File: rtl/ppm_pin_cell.sv */
// One pin's pad control: driver, pull-up, alternative select and input synchroniser.
`timescale 1ns/1ps
module ppm_pin_cell
  import ppm_pkg::*;
(
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Control from the register file
  input  wire ppm_mode_type mode,
  input  wire logic         out_level,
  // Pad
  input  wire logic         pad_in,
  output logic              pad_out,
  output logic              pad_oe_n,
  output logic              pull_up_en,
  output logic              alt_sel,
  // Synchronised pad level
  output logic              pin_level
);

  logic sync_meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_meta <= 1'b0;
      pin_level <= 1'b0;
    end else begin
      sync_meta <= pad_in;
      pin_level <= sync_meta;
    end
  end

  // driver off for inputs
  // Open drain only ever pulls low; a one releases the pad.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out  <= 1'b0;
      pad_oe_n <= 1'b1;
    end else begin
      unique case (mode)
        PPM_PUSH_PULL: begin
          pad_out  <= out_level;
          pad_oe_n <= 1'b0;
        end
        PPM_OPEN_DRAIN: begin
          pad_out  <= 1'b0;
          pad_oe_n <= out_level;
        end
        default: begin
          pad_out  <= 1'b0;
          pad_oe_n <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_up_en <= 1'b0;
      alt_sel    <= 1'b0;
    end else begin
      pull_up_en <= (mode == PPM_PULL_UP);
      alt_sel    <= (mode == PPM_ALT);
    end
  end

  property p_pull_up_only;
    @(posedge pclk) disable iff (!presetn)
      pull_up_en |-> $past(mode) == PPM_PULL_UP;
  endproperty
  a_pull_up_only: assert property (p_pull_up_only)
    else $error("Pull-up enabled outside pull-up mode.");

  property p_driver_off;
    @(posedge pclk) disable iff (!presetn)
      ppm_is_input(mode) |=> pad_oe_n && !pad_out;
  endproperty
  a_driver_off: assert property (p_driver_off)
    else $error("Driver enabled in an input or alternative mode.");

  property p_push_pull_level;
    @(posedge pclk) disable iff (!presetn)
      (mode == PPM_PUSH_PULL) |=> !pad_oe_n && (pad_out == $past(out_level));
  endproperty
  a_push_pull_level: assert property (p_push_pull_level)
    else $error("Push-pull pad does not follow the data bit.");

endmodule : ppm_pin_cell

/* File: sim/ppm_board_model.sv */
// Board-side model of the pins: resolves each wire from the block, the board and the pull-up.
`timescale 1ns/1ps
module ppm_board_model #(
  parameter int N = 7
) (
  // Clock for the floating-wire pattern
  input  wire logic         pclk,
  // Pad controls from the block
  input  wire logic [N-1:0] pad_out,
  input  wire logic [N-1:0] pad_oe_n,
  input  wire logic [N-1:0] pull_up_en,
  // Board drivers
  input  wire logic [N-1:0] ext_en,
  input  wire logic [N-1:0] ext_level,
  // Resolved wire levels
  output logic [N-1:0]      pad_in
);
  logic flip = 1'b0;

  // A released wire with no pull-up toggles, so a stale level is never read back as valid.
  always @(posedge pclk) begin
    flip <= ~flip;
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_level[i];
      else if (pull_up_en[i]) pad_in[i] = 1'b1;
      else pad_in[i] = flip;
    end
  end
endmodule : ppm_board_model

/* File: sim/tb_top.sv */
// Self-checking bench for the port pin mode control block.
`timescale 1ns/1ps
module tb_top;
  import ppm_pkg::*;
  localparam logic [ADDR_WIDTH-1:0] A_P3D = {2'b00, IDX_P3_DATA, 2'b00};
  localparam logic [ADDR_WIDTH-1:0] A_P4D = {2'b00, IDX_P4_DATA, 2'b00};
  localparam logic [ADDR_WIDTH-1:0] A_P3M = {2'b00, IDX_P3_MODE, 2'b00};
  localparam logic [ADDR_WIDTH-1:0] A_P4M = {2'b00, IDX_P4_MODE, 2'b00};
  localparam logic [ADDR_WIDTH-1:0] A_UNM = 12'h000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_WIDTH-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready, pslverr, adc_input_thirteen, adc_input_fourteen;
  logic [2:0] p3_pad_out, p3_pad_oe_n, p3_pull_up_en;
  logic [3:0] p4_pad_out, p4_pad_oe_n, p4_pull_up_en;
  logic [6:0] pad_lvl;
  logic [6:0] ext_en = 7'h00;
  logic [6:0] ext_lvl = 7'h00;
  logic snap = 1'b0;
  logic [32:0] exp_q[$];
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  integer seed = 32'h1ec7;

  ppm_port_ctrl i_ppm_port_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .p3_pad_in(pad_lvl[2:0]), .p3_pad_out(p3_pad_out),
    .p3_pad_oe_n(p3_pad_oe_n), .p3_pull_up_en(p3_pull_up_en), .p4_pad_in(pad_lvl[6:3]),
    .p4_pad_out(p4_pad_out), .p4_pad_oe_n(p4_pad_oe_n), .p4_pull_up_en(p4_pull_up_en),
    .adc_input_thirteen(adc_input_thirteen), .adc_input_fourteen(adc_input_fourteen));

  ppm_board_model #(.N(7)) i_ppm_board_model (.pclk(pclk),
    .pad_out({p4_pad_out, p3_pad_out}), .pad_oe_n({p4_pad_oe_n, p3_pad_oe_n}),
    .pull_up_en({p4_pull_up_en, p3_pull_up_en}), .ext_en(ext_en), .ext_level(ext_lvl),
    .pad_in(pad_lvl));

  always #2 pclk = ~pclk;

  task automatic report_and_stop();
    if (exp_q.size() != 0) n_mismatch++;
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic compare(input logic [32:0] got);
    logic [32:0] e;
    comparisons++;
    if (exp_q.size() == 0) e = 'x;
    else e = exp_q.pop_front();
    if (got !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, got);
    end
  endtask : compare

  // The masked drive value ignores pad_out while the driver is off.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) compare({pslverr, prdata});
    if (snap) compare({10'h000, adc_input_fourteen, adc_input_thirteen, p3_pull_up_en,
      p3_pad_oe_n, p3_pad_out & ~p3_pad_oe_n, p4_pull_up_en, p4_pad_oe_n,
      p4_pad_out & ~p4_pad_oe_n});
  end

  // Caller is just past a rising edge; returns at the edge that completes the access.
  task automatic apb_xfer(input logic wr, input logic [ADDR_WIDTH-1:0] a, input logic [7:0] d,
                          input logic [3:0] st);
    logic [31:0] rnd;
    rnd = $random(seed);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {rnd[31:8], d};
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
  endtask : apb_xfer

  task automatic apb_read(input logic [ADDR_WIDTH-1:0] a, input logic err, input logic [7:0] v);
    exp_q.push_back({err, 24'h00_0000, v});
    apb_xfer(1'b0, a, 8'h00, 4'h0);
  endtask : apb_read

  task automatic apb_idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb_idle

  function automatic logic [2:0] wide(input logic [1:0] c);
    wide = c[1] ? (c[0] ? 3'h4 : 3'h3) : {2'b00, c[0]};
  endfunction : wide

  // Fields are read-back, alt select, pull-up, oe_n, masked drive.
  function automatic logic [4:0] pin(input logic [2:0] c, input logic d, input logic e);
    if (c[2]) pin = {d, 3'b000, d};
    else if (c == M3_OPEN_DRAIN) pin = {d, 2'b00, d, 1'b0};
    else pin = {e, c == M3_ALT, c == M3_PULL_UP, 2'b10};
  endfunction : pin

  task automatic run_case(input logic wr, input logic rel, input logic [7:0] m3,
                          input logic [7:0] m4, input logic [7:0] d3, input logic [7:0] d4,
                          input logic [6:0] lv);
    logic [4:0] r;
    logic [2:0] c;
    logic [7:0] r3;
    logic [7:0] r4;
    logic [6:0] pu;
    logic [6:0] oe;
    logic [6:0] o;
    logic [1:0] alt;
    r3 = d3;
    r4 = d4;
    alt = 2'b00;
    for (int i = 0; i < 7; i++) begin
      if (i > 2) c = wide(m4[2*i-6 +: 2]);
      else if (i == 2) c = wide(m3[7:6]);
      else c = m3[3*i +: 3];
      r = pin(c, (i > 2) ? d4[i+1] : d3[i], lv[i]);
      {pu[i], oe[i], o[i]} = r[2:0];
      if (i < 2) alt[i] = r[3];
      if (i > 2) r4[i+1] = r[4];
      else r3[i] = r[4];
    end
    ext_en <= rel ? 7'h00 : oe;
    ext_lvl <= lv;
    if (wr) begin
      apb_xfer(1'b1, A_P3M, m3, 4'hf);
      apb_xfer(1'b1, A_P4M, m4, 4'hf);
      apb_xfer(1'b1, A_P3D, d3, 4'hf);
      apb_xfer(1'b1, A_P4D, d4, 4'hf);
      apb_idle();
    end
    repeat (4) @(posedge pclk);
    exp_q.push_back({10'h000, alt, pu[2:0], oe[2:0], o[2:0], pu[6:3], oe[6:3], o[6:3]});
    snap <= 1'b1;
    @(posedge pclk);
    snap <= 1'b0;
    apb_read(A_P3D, 1'b0, r3);
    apb_read(A_P3M, 1'b0, m3);
    apb_read(A_P4D, 1'b0, r4);
    apb_read(A_P4M, 1'b0, m4);
    apb_idle();
  endtask : run_case

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    run_case(1'b0, 1'b0, 8'h9b, 8'haa, 8'h07, 8'hff, 7'($random(seed)));
    for (int k = 0; k < 8; k++) begin
      run_case(1'b1, 1'b0, {2'(k), 3'(k), 3'(k + 3)}, {2'(k), 2'(k + 1), 2'(k + 2), 2'(k + 3)},
        8'($random(seed)), 8'($random(seed)), 7'($random(seed)));
    end
    run_case(1'b1, 1'b1, 8'h49, 8'h55, 8'h00, 8'h00, 7'h7f);
    apb_xfer(1'b1, A_UNM, 8'h5a, 4'hf);
    apb_read(A_UNM, 1'b1, 8'h00);
    apb_xfer(1'b1, A_P3M, 8'h24, 4'he);
    apb_read(A_P3M, 1'b0, 8'h49);
    apb_idle();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    run_case(1'b0, 1'b0, 8'h9b, 8'haa, 8'h07, 8'hff, 7'($random(seed)));
    report_and_stop();
  end
endmodule : tb_top
